/* File: rtl/vcom_pkg.sv */
// shared constants for the serial bridge between board controller and target
// assumes a single 100 MHz clock feeding both ends
package vcom_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned BAUD_DEFAULT = 115_200;
    localparam int unsigned BAUD_MIN = 9_600;
    localparam int unsigned BAUD_MAX = 921_600;
    localparam int unsigned DATA_BITS = 8;
    localparam int unsigned FIFO_DEPTH = 16;
    localparam int unsigned DIV_W = 16;
    localparam logic [DIV_W-1:0] DIV_DEFAULT = DIV_W'(CLK_HZ / BAUD_DEFAULT);
    localparam logic [DIV_W-1:0] DIV_MIN = DIV_W'(CLK_HZ / BAUD_MAX);
    localparam logic [DIV_W-1:0] DIV_MAX = DIV_W'(CLK_HZ / BAUD_MIN);
    localparam logic [3:0] LAST_BIT = 4'h9;
    localparam logic [3:0] STOP_BIT = 4'h9;
    // apb register map, one word each
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_DIV = 8'h04;
    localparam logic [7:0] ADDR_TXDATA = 8'h08;
    localparam logic [7:0] ADDR_RXDATA = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    // ctrl fields
    localparam int unsigned CTRL_EN = 0;
    localparam int unsigned CTRL_HS_LO = 1;
    localparam int unsigned CTRL_SOCK = 3;
    localparam int unsigned CTRL_USB = 4;
    localparam int unsigned SLV_ERR_BIT = 31;
    typedef enum logic [1:0] {HS_DISABLED, HS_RTS, HS_CTS, HS_RTSCTS} handshake_e;
    // host path selection
    typedef enum logic [1:0] {PATH_NONE, PATH_USB, PATH_SOCKET} path_e;
endpackage : vcom_pkg

/* File: rtl/vcom_if.sv */
// link between board controller and target uart
// resolves cts here from its output and enable, high while the output is not enabled
`timescale 1ns/10ps
`default_nettype none
interface vcom_if;
    logic tx;
    logic rx;
    logic cts_o;
    logic cts_oe_b;
    logic rts;
    logic enable;
    logic cts;
    assign cts = cts_oe_b ? 1'b1 : cts_o;
    modport ctrl (input tx, input rts, input enable, output rx, output cts_o, output cts_oe_b);
    modport target (output tx, output rts, output enable, input rx, input cts);
endinterface : vcom_if
`default_nettype wire

/* File: rtl/vcom_fifo.sv */
// synchronous valid/ready fifo
// assumes both sides on the one clock
`timescale 1ns/10ps
`default_nettype none
module vcom_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 16
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_flush,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;
    assign o_in_ready = (cnt_r != (AW+1)'(DEPTH));
    assign o_out_valid = (cnt_r != '0);
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;
    assign o_out_data = mem[rp_r];
    always_ff @(posedge i_ref_clk)
    begin
        if (push)
            mem[wp_r] <= i_in_data;
    end
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end
        else if (i_flush)
        begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end
        else
        begin
            if (push)
                wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
            if (pop)
                rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : vcom_fifo
`default_nettype wire

/* File: rtl/vcom_ctrl.sv */
// Contract
// R01: target sends on tx, controller on rx
// R02: data passes only while enable asserted
// R03: default 115200 8n1, no handshake
// R04: baud 9600..921600, four handshake modes
// R05: drop cts when receive buffer full
// R06: target halts new characters while cts low
// R07: rts checking stops further characters to target
// R08: character in flight always completes
// R09: disabled: cts undriven, rts ignored
// R10: rts mode: drive cts, ignore rts
// R11: cts mode: cts undriven, gate on rts
// R12: rtscts: drive cts and gate on rts
// R13: no rts checking: send regardless
// R14: target drives rts when controller checks it
// R15: one host path, socket beats usb
// R16: idle high, start low, lsb first, stop high
// board-controller end: apb registers, uart engine, receive fifo
// assumes apb on i_ref_clk; link pins come from another domain
`timescale 1ns/10ps
`default_nettype none
module vcom_ctrl
    import vcom_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    vcom_if.ctrl link
);
    logic [1:0] tx_s_r;
    logic [1:0] rts_s_r;
    logic [1:0] en_s_r;
    logic enable_r;
    handshake_e hs_r;
    logic sock_r;
    logic usb_r;
    logic [DIV_W-1:0] div_r;
    logic [DATA_BITS-1:0] txd_r;
    logic txd_valid_r;
    logic [DATA_BITS-1:0] rxd_r;
    logic rx_ovr_r;
    path_e path;
    logic gate_rts;
    logic drive_cts;
    logic open_link;
    logic acc;
    logic wr;
    logic [DIV_W-1:0] tx_cnt_r;
    logic [3:0] tx_bit_r;
    logic [9:0] tx_sh_r;
    logic tx_busy_r;
    logic [DIV_W-1:0] rx_cnt_r;
    logic [3:0] rx_bit_r;
    logic [DATA_BITS-1:0] rx_sh_r;
    logic rx_busy_r;
    logic rx_push;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_pop;
    logic [DATA_BITS-1:0] fifo_out;
    logic rx_pin;
    logic rts_pin;

    // synchronisers
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            tx_s_r <= 2'b11;
            rts_s_r <= 2'b00;
            en_s_r <= 2'b00;
        end
        else
        begin
            tx_s_r <= {tx_s_r[0], link.tx};
            rts_s_r <= {rts_s_r[0], link.rts};
            en_s_r <= {en_s_r[0], link.enable};
        end
    end
    assign rx_pin = tx_s_r[1];
    assign rts_pin = rts_s_r[1];

    assign path = sock_r ? PATH_SOCKET : (usb_r ? PATH_USB : PATH_NONE); // R15
    assign open_link = en_s_r[1] && enable_r && (path != PATH_NONE); // R02
    assign gate_rts = (hs_r == HS_CTS) || (hs_r == HS_RTSCTS); // R07 R11 R12 R13
    assign drive_cts = (hs_r == HS_RTS) || (hs_r == HS_RTSCTS); // R09 R10 R12
    assign link.cts_oe_b = !drive_cts; // R09
    assign link.cts_o = fifo_in_ready; // R05
    assign link.rx = tx_sh_r[0]; // R01

    // apb slave, zero wait
    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign pready = 1'b1;
    always_comb
    begin
        pslverr = 1'b0;
        prdata = '0;
        case (paddr)
            ADDR_CTRL: prdata = {27'h0, usb_r, sock_r, hs_r, enable_r};
            ADDR_DIV: prdata = {16'h0, div_r};
            ADDR_TXDATA: prdata = {24'h0, txd_r};
            ADDR_RXDATA: prdata = {24'h0, fifo_out};
            ADDR_STATUS: prdata = {26'h0, path, rx_ovr_r, fifo_out_valid, txd_valid_r,
                tx_busy_r};
            default: pslverr = acc;
        endcase
    end
    assign fifo_pop = acc && !pwrite && (paddr == ADDR_RXDATA);

    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            enable_r <= 1'b0;
            hs_r <= HS_DISABLED; // R03
            sock_r <= 1'b0;
            usb_r <= 1'b0;
            div_r <= DIV_DEFAULT; // R03
        end
        else if (wr && paddr == ADDR_CTRL)
        begin
            enable_r <= pwdata[CTRL_EN];
            hs_r <= handshake_e'(pwdata[CTRL_HS_LO +: 2]); // R04
            sock_r <= pwdata[CTRL_SOCK];
            usb_r <= pwdata[CTRL_USB];
        end
        else if (wr && paddr == ADDR_DIV)
        begin
            if (pwdata[31:DIV_W] != '0 || pwdata[DIV_W-1:0] > DIV_MAX) // R04
                div_r <= DIV_MAX;
            else if (pwdata[DIV_W-1:0] < DIV_MIN) // R04
                div_r <= DIV_MIN;
            else
                div_r <= pwdata[DIV_W-1:0];
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            txd_r <= '0;
            txd_valid_r <= 1'b0;
        end
        else if (wr && paddr == ADDR_TXDATA && !txd_valid_r)
        begin
            txd_r <= pwdata[DATA_BITS-1:0];
            txd_valid_r <= 1'b1;
        end
        else if (!tx_busy_r && txd_valid_r && open_link && (!gate_rts || rts_pin)) // R07 R13
            txd_valid_r <= 1'b0;
    end

    // transmitter toward target
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            tx_busy_r <= 1'b0;
            tx_sh_r <= '1;
            tx_cnt_r <= '0;
            tx_bit_r <= '0;
        end
        else if (!tx_busy_r)
        begin
            if (txd_valid_r && open_link && (!gate_rts || rts_pin)) // R11 R12
            begin
                tx_busy_r <= 1'b1;
                tx_sh_r <= {1'b1, txd_r, 1'b0}; // R16
                tx_cnt_r <= div_r - 1'b1;
                tx_bit_r <= '0;
            end
        end
        else if (tx_cnt_r != '0)
            tx_cnt_r <= tx_cnt_r - 1'b1;
        else if (tx_bit_r == LAST_BIT) // R08
        begin
            tx_busy_r <= 1'b0;
            tx_sh_r <= '1;
        end
        else
        begin
            tx_sh_r <= {1'b1, tx_sh_r[9:1]};
            tx_bit_r <= tx_bit_r + 1'b1;
            tx_cnt_r <= div_r - 1'b1;
        end
    end

    // receiver from target, samples mid bit
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            rx_busy_r <= 1'b0;
            rx_cnt_r <= '0;
            rx_bit_r <= '0;
            rx_sh_r <= '0;
            rx_push <= 1'b0;
            rx_ovr_r <= 1'b0;
        end
        else
        begin
            rx_push <= 1'b0;
            if (rx_push && !fifo_in_ready)
                rx_ovr_r <= 1'b1;
            else if (wr && paddr == ADDR_STATUS && pwdata[2])
                rx_ovr_r <= 1'b0;
            if (!rx_busy_r)
            begin
                if (!rx_pin && open_link) // R02 R16
                begin
                    rx_busy_r <= 1'b1;
                    rx_cnt_r <= {1'b0, div_r[DIV_W-1:1]};
                    rx_bit_r <= '0;
                end
            end
            else if (rx_cnt_r != '0)
                rx_cnt_r <= rx_cnt_r - 1'b1;
            else
            begin
                rx_cnt_r <= div_r - 1'b1;
                rx_bit_r <= rx_bit_r + 1'b1;
                if (rx_bit_r == '0 && rx_pin)
                    rx_busy_r <= 1'b0;
                else if (rx_bit_r == STOP_BIT)
                begin
                    rx_busy_r <= 1'b0;
                    rx_push <= rx_pin;
                end
                else
                    rx_sh_r <= (rx_bit_r == '0) ? rx_sh_r : {rx_pin, rx_sh_r[7:1]};
            end
        end
    end

    vcom_fifo #(
        .WIDTH(DATA_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_rx_fifo (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_flush(!open_link),
        .i_in_valid(rx_push),
        .o_in_ready(fifo_in_ready),
        .i_in_data(rx_sh_r),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(fifo_pop),
        .o_out_data(fifo_out)
    );
endmodule : vcom_ctrl
`default_nettype wire

/* File: rtl/vcom_target.sv */
// target-side uart end with rts/cts handshake
// assumes link pins come from another domain
`timescale 1ns/10ps
`default_nettype none
module vcom_target
    import vcom_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_enable,
    input wire logic i_hs_en,
    input wire logic [DIV_W-1:0] i_div,
    input wire logic i_tx_valid,
    output logic o_tx_ready,
    input wire logic [DATA_BITS-1:0] i_tx_data,
    input wire logic i_rx_hold,
    output logic o_rx_valid,
    output logic [DATA_BITS-1:0] o_rx_data,
    vcom_if.target link
);
    logic [1:0] rx_s_r;
    logic [1:0] cts_s_r;
    logic [DIV_W-1:0] tx_cnt_r;
    logic [3:0] tx_bit_r;
    logic [9:0] tx_sh_r;
    logic tx_busy_r;
    logic [DIV_W-1:0] rx_cnt_r;
    logic [3:0] rx_bit_r;
    logic [DATA_BITS-1:0] rx_sh_r;
    logic rx_busy_r;
    logic go;
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            rx_s_r <= 2'b11;
            cts_s_r <= 2'b00;
        end
        else
        begin
            rx_s_r <= {rx_s_r[0], link.rx};
            cts_s_r <= {cts_s_r[0], link.cts};
        end
    end
    assign link.enable = i_enable; // R02
    assign link.rts = !i_rx_hold; // R14
    assign link.tx = tx_sh_r[0]; // R01
    assign go = i_enable && (!i_hs_en || cts_s_r[1]); // R06
    assign o_tx_ready = !tx_busy_r && go;
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            tx_busy_r <= 1'b0;
            tx_sh_r <= '1;
            tx_cnt_r <= '0;
            tx_bit_r <= '0;
        end
        else if (!tx_busy_r)
        begin
            if (i_tx_valid && go)
            begin
                tx_busy_r <= 1'b1;
                tx_sh_r <= {1'b1, i_tx_data, 1'b0}; // R16
                tx_cnt_r <= i_div - 1'b1;
                tx_bit_r <= '0;
            end
        end
        else if (tx_cnt_r != '0)
            tx_cnt_r <= tx_cnt_r - 1'b1;
        else if (tx_bit_r == LAST_BIT)
        begin
            tx_busy_r <= 1'b0;
            tx_sh_r <= '1;
        end
        else
        begin
            tx_sh_r <= {1'b1, tx_sh_r[9:1]};
            tx_bit_r <= tx_bit_r + 1'b1;
            tx_cnt_r <= i_div - 1'b1;
        end
    end
    // receiver keeps taking characters after rts drops
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            rx_busy_r <= 1'b0;
            rx_cnt_r <= '0;
            rx_bit_r <= '0;
            rx_sh_r <= '0;
            o_rx_valid <= 1'b0;
            o_rx_data <= '0;
        end
        else
        begin
            o_rx_valid <= 1'b0;
            if (!rx_busy_r)
            begin
                if (!rx_s_r[1] && i_enable) // R08
                begin
                    rx_busy_r <= 1'b1;
                    rx_cnt_r <= {1'b0, i_div[DIV_W-1:1]};
                    rx_bit_r <= '0;
                end
            end
            else if (rx_cnt_r != '0)
                rx_cnt_r <= rx_cnt_r - 1'b1;
            else
            begin
                rx_cnt_r <= i_div - 1'b1;
                rx_bit_r <= rx_bit_r + 1'b1;
                if (rx_bit_r == '0 && rx_s_r[1])
                    rx_busy_r <= 1'b0;
                else if (rx_bit_r == STOP_BIT)
                begin
                    rx_busy_r <= 1'b0;
                    o_rx_valid <= rx_s_r[1];
                    o_rx_data <= rx_sh_r;
                end
                else if (rx_bit_r != '0)
                    rx_sh_r <= {rx_s_r[1], rx_sh_r[7:1]};
            end
        end
    end
endmodule : vcom_target
`default_nettype wire

/* File: dv/vcom_link_chk.sv */
// checker for the serial link between the two uart ends
// assumes both ends run at BIT_CYC clocks per bit
`timescale 1ns/10ps
`default_nettype none
module vcom_link_chk #(
    parameter int BIT_CYC = 108
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic tx,
    input wire logic rx,
    input wire logic enable,
    input wire logic cts
);
    localparam int FRAME = 19 * BIT_CYC / 2;
    localparam int CLOSED = 12 * BIT_CYC;
    logic tx_q;
    logic rx_q;
    int tx_cnt;
    int rx_cnt;
    int closed_cnt;
    int cts_low_cnt;
    logic tx_start;
    logic rx_start;
    assign tx_start = tx_cnt == 0 && tx_q && !tx;
    assign rx_start = rx_cnt == 0 && rx_q && !rx;
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            tx_q <= 1'b1;
            rx_q <= 1'b1;
            tx_cnt <= 0;
            rx_cnt <= 0;
            closed_cnt <= 0;
            cts_low_cnt <= 0;
        end
        else
        begin
            tx_q <= tx;
            rx_q <= rx;
            tx_cnt <= tx_start ? FRAME : (tx_cnt > 0 ? tx_cnt - 1 : 0);
            rx_cnt <= rx_start ? FRAME : (rx_cnt > 0 ? rx_cnt - 1 : 0);
            closed_cnt <= enable ? 0 : (closed_cnt < CLOSED ? closed_cnt + 1 : CLOSED);
            cts_low_cnt <= cts ? 0 : cts_low_cnt + 1;
        end
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    tx_start_open_a: assert property (tx_start |-> enable)
        else $error("target started a character while closed");
    rx_start_open_a: assert property (rx_start |-> enable)
        else $error("controller started a character while closed");
    tx_start_bit_a: assert property (tx_cnt == FRAME - BIT_CYC / 2 |-> !tx)
        else $error("target start bit not low");
    rx_start_bit_a: assert property (rx_start |=> !rx [*8])
        else $error("controller start bit too short");
    tx_stop_bit_a: assert property (tx_cnt == 1 |-> tx)
        else $error("target stop bit not high");
    rx_stop_bit_a: assert property (rx_cnt == 1 |-> rx)
        else $error("controller stop bit not high");
    tx_held_off_a: assert property (tx_start |-> cts_low_cnt < 8)
        else $error("target started while clear to send low");
    closed_idle_a: assert property (closed_cnt == CLOSED |-> rx && tx)
        else $error("data line not idle on closed link");
endmodule : vcom_link_chk
`default_nettype wire

/* File: dv/tb_vcom_uart_flow_bridge.sv */
// testbench: controller and target ends joined by the link interface
// assumes a 100 MHz clock and apb access to the controller registers
`timescale 1ns/10ps
`default_nettype none
module tb_vcom_uart_flow_bridge;
    import vcom_pkg::*;
    localparam int BIT = 108;
    localparam int CHAR = 10 * BIT;
    logic i_ref_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic t_en = 1'b1;
    logic t_valid = 1'b0;
    logic t_hold = 1'b0;
    logic t_ready;
    logic t_rx_valid;
    logic [7:0] t_data = 8'h00;
    logic [7:0] t_rx_data;
    logic [7:0] last_rx = 8'h00;
    logic [31:0] rd;
    logic err;
    int n_mismatch = 0;
    int tests_run = 0;
    int n_rx = 0;
    logic [7:0] txq[$];
    vcom_if link();
    vcom_ctrl vcom_ctrl_inst (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link(link.ctrl));
    vcom_target vcom_target_inst (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_enable(t_en),
        .i_hs_en(1'b1), .i_div(DIV_W'(BIT)), .i_tx_valid(t_valid), .o_tx_ready(t_ready),
        .i_tx_data(t_data), .i_rx_hold(t_hold), .o_rx_valid(t_rx_valid),
        .o_rx_data(t_rx_data), .link(link.target));
    vcom_link_chk #(.BIT_CYC(BIT)) vcom_link_chk_inst (.i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b), .tx(link.tx), .rx(link.rx), .enable(link.enable), .cts(link.cts));
    always #5 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk)
    begin
        if (t_rx_valid === 1'b1)
        begin
            n_rx <= n_rx + 1;
            last_rx <= t_rx_data;
        end
        if (t_valid && t_ready === 1'b1)
            void'(txq.pop_front());
        t_valid <= txq.size() != 0;
        t_data <= txq.size() != 0 ? txq[0] : 8'h00;
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : conclude
    task automatic hang();
        n_mismatch++;
        conclude();
    endtask : hang
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge i_ref_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge i_ref_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n == 20)
            hang();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge i_ref_clk);
    endtask : apb
    task automatic rd_rx(output logic [7:0] b);
        int n;
        n = 0;
        do
        begin
            apb(1'b0, ADDR_STATUS, 32'h0);
            n++;
        end
        while (rd[2] !== 1'b1 && n < 3000);
        if (n == 3000)
            hang();
        apb(1'b0, ADDR_RXDATA, 32'h0);
        b = rd[7:0];
    endtask : rd_rx
    task automatic wait_rx(input int want, input int lim);
        int n;
        for (n = 0; n < lim && n_rx < want; n++)
            @(posedge i_ref_clk);
    endtask : wait_rx
    initial
    begin
        logic [7:0] b;
        int k;
        int m;
        repeat (3) @(posedge i_ref_clk);
        i_rst_b <= 1'b1;
        @(posedge i_ref_clk);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk("mode reset", 32'h0, 32'(rd[2:1]));
        apb(1'b0, ADDR_DIV, 32'h0);
        chk("div reset", 32'(CLK_HZ / BAUD_DEFAULT), 32'(rd[15:0]));
        apb(1'b1, ADDR_DIV, 32'd10);
        apb(1'b0, ADDR_DIV, 32'h0);
        chk("div low", 32'(CLK_HZ / BAUD_MAX), 32'(rd[15:0]));
        apb(1'b1, ADDR_DIV, 32'd20000);
        apb(1'b0, ADDR_DIV, 32'h0);
        chk("div high", 32'(CLK_HZ / BAUD_MIN), 32'(rd[15:0]));
        apb(1'b1, ADDR_DIV, 32'h10005);
        apb(1'b0, ADDR_DIV, 32'h0);
        chk("div wide", 32'(CLK_HZ / BAUD_MIN), 32'(rd[15:0]));
        apb(1'b1, ADDR_DIV, 32'(BIT));
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped", 32'h1, 32'(err));
        for (k = 3; k >= 0; k--)
        begin
            apb(1'b1, ADDR_CTRL, 32'h1 | (32'(k[1]) << CTRL_SOCK) | (32'(k[0]) << CTRL_USB));
            apb(1'b0, ADDR_STATUS, 32'h0);
            chk("path", k[1] ? 32'h2 : 32'(k[0]), 32'(rd[5:4]));
            m = n_rx;
            apb(1'b1, ADDR_TXDATA, 32'(8'h5a + k));
            wait_rx(m + 1, 2 * CHAR);
            chk("path rx", 32'(m + (k != 0)), 32'(n_rx));
        end
        apb(1'b1, ADDR_CTRL, 32'h11);
        repeat (2 * CHAR) @(posedge i_ref_clk);
        for (k = 0; k < 4; k++)
        begin
            apb(1'b1, ADDR_CTRL, 32'h11 | 32'(k << CTRL_HS_LO));
            chk("cts drive", 32'(!k[0]), 32'(link.cts_oe_b));
            t_hold <= 1'b1;
            for (m = 0; m < 50 && link.rts !== 1'b0; m++)
                @(posedge i_ref_clk);
            if (m == 50)
                hang();
            repeat (4) @(posedge i_ref_clk);
            m = n_rx;
            apb(1'b1, ADDR_TXDATA, 32'(8'h30 + k));
            wait_rx(m + 1, 2 * CHAR);
            chk("gated", 32'(m + (k < 2)), 32'(n_rx));
            t_hold <= 1'b0;
            wait_rx(m + 1, 3 * CHAR);
            chk("resumed", 32'(8'h30 + k), 32'(last_rx));
        end
        m = n_rx;
        apb(1'b1, ADDR_TXDATA, 32'hc3);
        for (k = 0; k < CHAR && link.rx !== 1'b0; k++)
            @(posedge i_ref_clk);
        if (k == CHAR)
            hang();
        t_hold <= 1'b1;
        wait_rx(m + 1, 2 * CHAR);
        chk("in flight", 32'hc3, 32'(last_rx));
        t_hold <= 1'b0;
        apb(1'b1, ADDR_CTRL, 32'h13);
        for (k = 0; k < 18; k++)
            txq.push_back(8'(8'h40 + k));
        for (k = 0; k < 20 * CHAR && link.cts !== 1'b0; k++)
            @(posedge i_ref_clk);
        if (k == 20 * CHAR)
            hang();
        repeat (2 * CHAR) @(posedge i_ref_clk);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("overrun", 32'h0, 32'(rd[3]));
        chk("cts full", 32'h0, 32'(link.cts));
        for (k = 0; k < 18; k++)
        begin
            rd_rx(b);
            chk("rx byte", 32'(8'h40 + k), 32'(b));
        end
        apb(1'b1, ADDR_CTRL, 32'h11);
        for (k = 0; k < 17; k++)
            txq.push_back(8'(8'h60 + k));
        for (k = 0; k < 20 * CHAR && txq.size() != 0; k++)
            @(posedge i_ref_clk);
        if (k == 20 * CHAR)
            hang();
        repeat (2 * CHAR) @(posedge i_ref_clk);
        chk("cts undriven", 32'h1, 32'(link.cts));
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("overrun set", 32'h1, 32'(rd[3]));
        apb(1'b1, ADDR_STATUS, 32'h4);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("overrun clear", 32'h0, 32'(rd[3]));
        chk("rx full", 32'h1, 32'(rd[2]));
        t_en <= 1'b0;
        repeat (4) @(posedge i_ref_clk);
        m = n_rx;
        apb(1'b1, ADDR_TXDATA, 32'h77);
        repeat (2 * CHAR) @(posedge i_ref_clk);
        chk("closed", 32'(m), 32'(n_rx));
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("closed pending", 32'h1, 32'(rd[1]));
        chk("closed flushed", 32'h0, 32'(rd[2]));
        t_en <= 1'b1;
        wait_rx(m + 1, 2 * CHAR);
        chk("reopened", 32'h77, 32'(last_rx));
        conclude();
    end
endmodule : tb_vcom_uart_flow_bridge
`default_nettype wire
